// File: rtl/pcd_pkg.sv
// Package for the three-port block with parallel slave port.
// Assumes word-aligned Avalon byte addresses of four times the index.
package pcd_pkg;
  localparam int ADDR_W = 10;
  localparam logic [7:0] IDX_PC_DATA = 8'h07;
  localparam logic [7:0] IDX_PD_DATA = 8'h08;
  localparam logic [7:0] IDX_PE_DATA = 8'h09;
  localparam logic [7:0] IDX_PC_DIR = 8'h87;
  localparam logic [7:0] IDX_PD_DIR = 8'h88;
  localparam logic [7:0] IDX_PE_CTRL = 8'h89;
  localparam logic [7:0] IDX_ANA_CFG = 8'h9F;
  localparam int IN_FULL_BIT = 7;
  localparam int OUT_FULL_BIT = 6;
  localparam int OVERRUN_BIT = 5;
  localparam int PSPEN_BIT = 4;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'hFF;
  localparam logic [2:0] PE_DIR_RST = 3'h7;
  localparam logic [2:0] ANA_RST = 3'h7;
  localparam logic [7:0] PC_ALT_MASK = 8'hC7;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
  typedef enum logic [0:0] {
    PCD_IDLE = 1'b0,
    PCD_DONE = 1'b1
  } pcd_bus_t;
endpackage

// File: rtl/pcd_pin_mux.sv
// Per-pin driver select: port latch and direction, or a peripheral.
// Assumes the override enables are already masked to legal pins.
`timescale 1ns/1ps
module pcd_pin_mux #(
  parameter int W = 8
) (
  input wire logic [W-1:0] latch_in,
  input wire logic [W-1:0] dir_in,
  input wire logic [W-1:0] alt_en_in,
  input wire logic [W-1:0] alt_out_in,
  input wire logic [W-1:0] alt_oe_n_in,
  output logic [W-1:0] pin_out,
  output logic [W-1:0] pin_oe_n_out
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_pin
      // A set direction bit floats the pin
      assign pin_out[i] = alt_en_in[i] ? alt_out_in[i] : latch_in[i];
      assign pin_oe_n_out[i] = alt_en_in[i] ? alt_oe_n_in[i] : dir_in[i];
    end
  endgenerate
endmodule

// File: rtl/pcd_slave_port.sv
// Parallel slave port strobes and status flags.
// Assumes strobe pins are synchronous to clk_in, sampled once per edge.
`timescale 1ns/1ps
module pcd_slave_port (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic other_rst_in,
  input wire logic en_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  input wire logic cs_n_in,
  input wire logic [7:0] data_in,
  input wire logic cpu_rd_in,
  input wire logic cpu_wr_in,
  input wire logic overrun_wr_in,
  input wire logic overrun_wdata_in,
  output logic [7:0] in_latch_out,
  output logic in_full_out,
  output logic out_full_out,
  output logic overrun_out,
  output logic drive_out,
  output logic wr_end_out
);
  logic wr_act;
  logic rd_act;
  logic wr_prev;
  logic rd_prev;
  logic rd_end;
  logic next_in_full;
  logic next_out_full;
  logic next_overrun;

  assign wr_act = en_in & ~wr_n_in & ~cs_n_in;
  assign rd_act = en_in & ~rd_n_in & ~cs_n_in;
  // Byte is taken when the write strobe ends, as on a real bus
  assign wr_end_out = wr_prev & ~wr_act;
  assign rd_end = rd_prev & ~rd_act;
  assign drive_out = rd_act;
  // Set wins over clear on every flag
  assign next_in_full = wr_end_out | (in_full_out & ~cpu_rd_in);
  assign next_out_full = cpu_wr_in | (out_full_out & ~rd_end);
  assign next_overrun = (wr_end_out & in_full_out) |
                        (overrun_wr_in ? overrun_wdata_in : overrun_out);

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_prev <= 1'b0;
      rd_prev <= 1'b0;
      in_full_out <= 1'b0;
      out_full_out <= 1'b0;
      overrun_out <= 1'b0;
    end else if (other_rst_in) begin
      wr_prev <= 1'b0;
      rd_prev <= 1'b0;
      in_full_out <= 1'b0;
      out_full_out <= 1'b0;
      overrun_out <= 1'b0;
    end else begin
      wr_prev <= wr_act;
      rd_prev <= rd_act;
      in_full_out <= next_in_full;
      out_full_out <= next_out_full;
      overrun_out <= next_overrun;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      in_latch_out <= 8'h00;
    end else if (wr_end_out) begin
      in_latch_out <= data_in;
    end
  end
endmodule

// File: rtl/pcd_ports.sv
// Top of the three-port block: Avalon-MM registers, pins, slave port.
// Assumes nrst_in is the power-on/brown-out reset and other_rst_in a
// synchronous pulse for every other reset source.
// Operation
// - Port C bits 0-2 carry timer and capture
// - Port C bits 6-7 carry USART; 3-5 plain
// - Power-on sets directions all ones; others keep data
// - Port D is eight bits, Schmitt inputs
// - Each port D pin has its own direction
// - Enable bit 4 turns port D into slave
// - Port D buffers TTL in slave mode
// - Pin n carries slave data bit n
// - Port E three pins, own directions, Schmitt
// - Slave mode makes port E the strobes
// - Analog E pins read as zero
// - E directions drive pins even when analog
// - Power-on makes E pins analog
// - Register 89h joins E directions and status
// - Direction one floats pin, zero drives latch
// - Output full flag until external read
// - Overrun on write over unread byte, sticky
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ps
module pcd_ports (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic other_rst_in,
  input wire logic [pcd_pkg::ADDR_W-1:0] address_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [3:0] byteenable_in,
  input wire logic [31:0] writedata_in,
  output logic [31:0] readdata_out,
  output logic waitrequest_out,
  input wire logic [7:0] pc_in,
  output logic [7:0] pc_out,
  output logic [7:0] pc_oe_n_out,
  input wire logic [7:0] pc_alt_en_in,
  input wire logic [7:0] pc_alt_out_in,
  input wire logic [7:0] pc_alt_oe_n_in,
  output logic [7:0] pc_alt_pin_out,
  input wire logic [7:0] pd_in,
  output logic [7:0] pd_out,
  output logic [7:0] pd_oe_n_out,
  output logic pd_ttl_sel_out,
  input wire logic [2:0] pe_in,
  output logic [2:0] pe_out,
  output logic [2:0] pe_oe_n_out,
  output logic pe_ttl_sel_out,
  output logic [2:0] pe_analog_sel_out
);
  import pcd_pkg::*;

  pcd_bus_t state;
  logic [7:0] pc_data;
  logic [7:0] pd_data;
  logic [2:0] pe_data;
  logic [7:0] pc_dir;
  logic [7:0] pd_dir;
  logic [2:0] pe_dir;
  logic [2:0] ana_cfg;
  logic slave_port_enable;
  logic input_full_flag;
  logic output_full_flag;
  logic input_overrun_flag;
  logic [7:0] pd_in_latch;
  logic psp_drive;
  logic psp_wr_end;
  logic req;
  logic acc_wr;
  logic acc_rd;
  logic lane0;
  logic [7:0] wb;
  logic hit_pc_data;
  logic hit_pd_data;
  logic hit_pe_data;
  logic hit_pc_dir;
  logic hit_pd_dir;
  logic hit_pe_ctrl;
  logic hit_ana;
  logic [7:0] rd_byte;
  logic [7:0] pe_ctrl_rd;
  logic [7:0] pd_rd;
  logic [7:0] pc_alt_en;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] i);
    hit = (a[ADDR_W-1:2] == i);
  endfunction

  // Bus decode
  assign req = read_in | write_in;
  assign waitrequest_out = req & (state == PCD_IDLE);
  assign acc_wr = write_in & (state == PCD_DONE);
  assign acc_rd = read_in & (state == PCD_DONE);
  assign lane0 = byteenable_in[0];
  assign wb = writedata_in[7:0];
  assign hit_pc_data = hit(address_in, IDX_PC_DATA);
  assign hit_pd_data = hit(address_in, IDX_PD_DATA);
  assign hit_pe_data = hit(address_in, IDX_PE_DATA);
  assign hit_pc_dir = hit(address_in, IDX_PC_DIR);
  assign hit_pd_dir = hit(address_in, IDX_PD_DIR);
  assign hit_pe_ctrl = hit(address_in, IDX_PE_CTRL);
  assign hit_ana = hit(address_in, IDX_ANA_CFG);

  // Status and E directions share one register; bit 3 reads zero
  assign pe_ctrl_rd = {input_full_flag, output_full_flag,
                       input_overrun_flag, slave_port_enable,
                       1'b0, pe_dir};
  // Slave mode reads the input latch, not the pins
  assign pd_rd = slave_port_enable ? pd_in_latch : pd_in;

  assign rd_byte = hit_pc_data ? pc_in :
                   hit_pd_data ? pd_rd :
                   hit_pe_data ? {5'h00, pe_in & ~ana_cfg} :
                   hit_pc_dir ? pc_dir :
                   hit_pd_dir ? pd_dir :
                   hit_pe_ctrl ? pe_ctrl_rd :
                   hit_ana ? {5'h00, ana_cfg} :
                   8'h00;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= PCD_IDLE;
      readdata_out <= RD_UNMAPPED;
    end else if (state == PCD_IDLE && req) begin
      state <= PCD_DONE;
      readdata_out <= {24'h000000, rd_byte};
    end else begin
      state <= PCD_IDLE;
    end
  end

  // Data latches: defined after power-on, kept over other resets
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pc_data <= DATA_RST;
      pd_data <= DATA_RST;
      pe_data <= DATA_RST[2:0];
    end else if (acc_wr && lane0) begin
      if (hit_pc_data) begin
        pc_data <= wb;
      end else if (hit_pd_data) begin
        pd_data <= wb;
      end else if (hit_pe_data) begin
        pe_data <= wb[2:0];
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pc_dir <= DIR_RST;
      pd_dir <= DIR_RST;
      pe_dir <= PE_DIR_RST;
      slave_port_enable <= 1'b0;
      ana_cfg <= ANA_RST;
    end else if (other_rst_in) begin
      pc_dir <= DIR_RST;
      pd_dir <= DIR_RST;
      pe_dir <= PE_DIR_RST;
      slave_port_enable <= 1'b0;
      ana_cfg <= ANA_RST;
    end else if (acc_wr && lane0) begin
      if (hit_pc_dir) begin
        pc_dir <= wb;
      end else if (hit_pd_dir) begin
        pd_dir <= wb;
      end else if (hit_pe_ctrl) begin
        pe_dir <= wb[2:0];
        slave_port_enable <= wb[PSPEN_BIT];
      end else if (hit_ana) begin
        ana_cfg <= wb[2:0];
      end
    end
  end

  pcd_slave_port u_psp (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .other_rst_in(other_rst_in),
    .en_in(slave_port_enable),
    .rd_n_in(pe_in[0]),
    .wr_n_in(pe_in[1]),
    .cs_n_in(pe_in[2]),
    .data_in(pd_in),
    .cpu_rd_in(acc_rd & hit_pd_data & slave_port_enable),
    .cpu_wr_in(acc_wr & lane0 & hit_pd_data & slave_port_enable),
    .overrun_wr_in(acc_wr & lane0 & hit_pe_ctrl),
    .overrun_wdata_in(wb[OVERRUN_BIT]),
    .in_latch_out(pd_in_latch),
    .in_full_out(input_full_flag),
    .out_full_out(output_full_flag),
    .overrun_out(input_overrun_flag),
    .drive_out(psp_drive),
    .wr_end_out(psp_wr_end)
  );

  // Only timer, capture and USART pins may be taken over
  assign pc_alt_en = pc_alt_en_in & PC_ALT_MASK;
  assign pc_alt_pin_out = pc_in;

  pcd_pin_mux #(.W(8)) u_pc_mux (
    .latch_in(pc_data),
    .dir_in(pc_dir),
    .alt_en_in(pc_alt_en),
    .alt_out_in(pc_alt_out_in),
    .alt_oe_n_in(pc_alt_oe_n_in),
    .pin_out(pc_out),
    .pin_oe_n_out(pc_oe_n_out)
  );

  // Slave mode ignores port D directions; the host steers the bus
  pcd_pin_mux #(.W(8)) u_pd_mux (
    .latch_in(pd_data),
    .dir_in(pd_dir),
    .alt_en_in({8{slave_port_enable}}),
    .alt_out_in(pd_data),
    .alt_oe_n_in({8{~psp_drive}}),
    .pin_out(pd_out),
    .pin_oe_n_out(pd_oe_n_out)
  );

  // E pins obey their directions even in analog or slave use
  assign pe_out = pe_data;
  assign pe_oe_n_out = pe_dir;
  assign pe_analog_sel_out = ana_cfg;
  assign pd_ttl_sel_out = slave_port_enable;
  assign pe_ttl_sel_out = slave_port_enable;

  // Helper for the checks below
  logic pe_rd_hit;
  assign pe_rd_hit = acc_rd & hit_pe_data;

  property p_one_wait;
    @(posedge clk_in) disable iff (!nrst_in)
    (req && state == PCD_IDLE) |-> waitrequest_out ##1 !waitrequest_out;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("bus answer not after one wait cycle");

  property p_dir_reset;
    @(posedge clk_in) disable iff (!nrst_in)
    other_rst_in |=> (pc_dir == 8'hFF && pd_dir == 8'hFF &&
                      pe_dir == 3'h7);
  endproperty
  a_dir_reset: assert property (p_dir_reset)
    else $error("directions not all ones after reset");

  property p_data_kept;
    @(posedge clk_in) disable iff (!nrst_in)
    (other_rst_in && !acc_wr) |=>
      (pc_data == $past(pc_data) && pd_data == $past(pd_data));
  endproperty
  a_data_kept: assert property (p_data_kept)
    else $error("data latch changed by other reset");

  property p_pd_dir;
    @(posedge clk_in) disable iff (!nrst_in)
    !slave_port_enable |-> (pd_oe_n_out == pd_dir && pd_out == pd_data);
  endproperty
  a_pd_dir: assert property (p_pd_dir)
    else $error("port D pins not steered by direction");

  property p_psp_drive;
    @(posedge clk_in) disable iff (!nrst_in)
    (slave_port_enable && !pe_in[0] && !pe_in[2]) |->
      (pd_oe_n_out == 8'h00 && pd_out == pd_data);
  endproperty
  a_psp_drive: assert property (p_psp_drive)
    else $error("slave read does not drive port D");

  property p_ttl_sel;
    @(posedge clk_in) disable iff (!nrst_in)
    (pd_ttl_sel_out == slave_port_enable) &&
      (pe_ttl_sel_out == slave_port_enable);
  endproperty
  a_ttl_sel: assert property (p_ttl_sel)
    else $error("buffer type does not follow slave mode");

  property p_analog_zero;
    @(posedge clk_in) disable iff (!nrst_in)
    pe_rd_hit |-> ((readdata_out[2:0] & ana_cfg) == 3'h0);
  endproperty
  a_analog_zero: assert property (p_analog_zero)
    else $error("analog pin read not zero");

  property p_e_dir;
    @(posedge clk_in) disable iff (!nrst_in)
    pe_oe_n_out == pe_dir;
  endproperty
  a_e_dir: assert property (p_e_dir)
    else $error("port E driver ignores direction");

  property p_in_full_set;
    @(posedge clk_in) disable iff (!nrst_in)
    (psp_wr_end && !other_rst_in) |=>
      (input_full_flag && pd_in_latch == $past(pd_in));
  endproperty
  a_in_full_set: assert property (p_in_full_set)
    else $error("input full not set by external write");

  property p_out_full_set;
    @(posedge clk_in) disable iff (!nrst_in)
    (acc_wr && lane0 && hit_pd_data && slave_port_enable &&
     !other_rst_in) |=> output_full_flag;
  endproperty
  a_out_full_set: assert property (p_out_full_set)
    else $error("output full not set by CPU write");

  property p_overrun_set;
    @(posedge clk_in) disable iff (!nrst_in)
    (psp_wr_end && input_full_flag && !other_rst_in) |=>
      input_overrun_flag;
  endproperty
  a_overrun_set: assert property (p_overrun_set)
    else $error("overrun not flagged");

  property p_pc_fixed;
    @(posedge clk_in) disable iff (!nrst_in)
    pc_oe_n_out[5:3] == pc_dir[5:3];
  endproperty
  a_pc_fixed: assert property (p_pc_fixed)
    else $error("plain port C pin taken over");

  property p_pc_alt;
    @(posedge clk_in) disable iff (!nrst_in)
    pc_alt_en_in[2] |-> (pc_oe_n_out[2] == pc_alt_oe_n_in[2] &&
                         pc_out[2] == pc_alt_out_in[2]);
  endproperty
  a_pc_alt: assert property (p_pc_alt)
    else $error("capture pin not given to peripheral");

  c_psp_write: cover property (@(posedge clk_in) disable iff (!nrst_in)
    psp_wr_end);
  c_psp_read: cover property (@(posedge clk_in) disable iff (!nrst_in)
    output_full_flag ##[1:50] !output_full_flag);
  c_overrun: cover property (@(posedge clk_in) disable iff (!nrst_in)
    $rose(input_overrun_flag));
endmodule

// File: verification/pcd_ext_cpu.sv
// External processor model on the slave port strobes and data pins.
// Assumes the bench resolves pin levels from the device's output enables and
// that every task is entered just after a rising clock edge.
`timescale 1ns/1ps
module pcd_ext_cpu (
  input wire logic clk_in,
  input wire logic [7:0] pd_in,
  output logic [2:0] strobe_n_out,
  output logic [7:0] data_out
);
  initial begin
    strobe_n_out = 3'h7;
    data_out = 8'h00;
  end
  // Bit order: [0] read_n, [1] write_n, [2] select_n, all active low
  task automatic ext_write(input logic [7:0] d);
    strobe_n_out <= 3'h1;
    data_out <= d;
    @(posedge clk_in);
    strobe_n_out <= 3'h7;
    @(posedge clk_in);
    // Released bus shows the inverse so stale data never looks valid
    data_out <= ~d;
    @(posedge clk_in);
  endtask
  task automatic ext_read(output logic [7:0] d);
    strobe_n_out <= 3'h2;
    @(posedge clk_in);
    #1;
    d = pd_in;
    @(posedge clk_in);
    strobe_n_out <= 3'h7;
    @(posedge clk_in);
  endtask
endmodule

// File: verification/tb_ports_cde_with_psp_control.sv
// Self-checking bench for the three-port block and its slave port.
// Assumes the register map of pcd_pkg and the model pcd_ext_cpu.
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    num_checks++; \
    if ((g) !== (e)) begin \
      n_mismatch++; \
      $display("unexpected at %0t: got %0h want %0h", $time, g, e); \
    end \
  end
module tb_ports_cde_with_psp_control;
  import pcd_pkg::*;
  logic clk_in, nrst_in, other_rst_in, read_in, write_in, waitrequest_out;
  logic [ADDR_W-1:0] address_in;
  logic [3:0] byteenable_in;
  logic [31:0] writedata_in, readdata_out;
  logic [7:0] pc_in, pc_out, pc_oe_n_out, pc_alt_pin_out, pc_ext;
  logic [7:0] pc_alt_en_in, pc_alt_out_in, pc_alt_oe_n_in;
  logic [7:0] pd_in, pd_out, pd_oe_n_out, ext_pd, rd;
  logic pd_ttl_sel_out, pe_ttl_sel_out;
  logic [2:0] pe_in, pe_out, pe_oe_n_out, pe_analog_sel_out, ext_pe;
  int n_mismatch, num_checks;
  // Pin level: device drives where its enable is low, else the far side
  assign pc_in = (pc_out & ~pc_oe_n_out) | (pc_ext & pc_oe_n_out);
  assign pd_in = (pd_out & ~pd_oe_n_out) | (ext_pd & pd_oe_n_out);
  assign pe_in = (pe_out & ~pe_oe_n_out) | (ext_pe & pe_oe_n_out);
  pcd_ports dut (.clk_in, .nrst_in, .other_rst_in, .address_in, .read_in,
    .write_in, .byteenable_in, .writedata_in, .readdata_out,
    .waitrequest_out, .pc_in, .pc_out, .pc_oe_n_out, .pc_alt_en_in,
    .pc_alt_out_in, .pc_alt_oe_n_in, .pc_alt_pin_out, .pd_in, .pd_out,
    .pd_oe_n_out, .pd_ttl_sel_out, .pe_in, .pe_out, .pe_oe_n_out,
    .pe_ttl_sel_out, .pe_analog_sel_out);
  pcd_ext_cpu ext (.clk_in, .pd_in, .strobe_n_out(ext_pe),
    .data_out(ext_pd));
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [7:0] d, output logic [7:0] q);
    int n;
    logic ok;
    address_in <= {idx, 2'b00};
    read_in <= !w;
    write_in <= w;
    writedata_in <= {24'h0, d};
    n = 0;
    ok = 1'b0;
    // Waitrequest and read data are both taken at the accepting edge
    while (!ok) begin
      @(posedge clk_in);
      ok = (waitrequest_out === 1'b0);
      n++;
      if (n > 20) begin
        n_mismatch++;
        conclude();
      end
    end
    q = readdata_out[7:0];
    read_in <= 1'b0;
    write_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, idx, d, q);
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, idx, 8'h00, q);
    `CHK(q, e)
  endtask
  initial begin
    nrst_in = 1'b0;
    other_rst_in = 1'b0;
    read_in = 1'b0;
    write_in = 1'b0;
    address_in = '0;
    byteenable_in = 4'h1;
    writedata_in = 32'h0000_0000;
    pc_ext = 8'h5A;
    pc_alt_en_in = 8'h00;
    pc_alt_out_in = 8'h00;
    pc_alt_oe_n_in = 8'hFF;
    n_mismatch = 0;
    num_checks = 0;
    repeat (12) @(posedge clk_in);
    nrst_in <= 1'b1;
    `CHK(pc_oe_n_out, 8'hFF)
    `CHK(pe_analog_sel_out, 3'h7)
    rdc(IDX_PC_DIR, DIR_RST);
    rdc(IDX_PD_DIR, DIR_RST);
    rdc(IDX_PE_CTRL, 8'h07);
    rdc(IDX_ANA_CFG, 8'h07);
    rdc(8'h10, 8'h00);
    $display("test reset values done");
    wr(IDX_PC_DIR, 8'h0F);
    wr(IDX_PC_DATA, 8'hA5);
    `CHK(pc_oe_n_out, 8'h0F)
    rdc(IDX_PC_DATA, 8'hAA);
    byteenable_in <= 4'hE;
    wr(IDX_PC_DATA, 8'h00);
    byteenable_in <= 4'h1;
    rdc(IDX_PC_DATA, 8'hAA);
    pc_alt_en_in <= 8'hFF;
    pc_alt_out_in <= 8'h3C;
    pc_alt_oe_n_in <= 8'h80;
    @(posedge clk_in);
    `CHK(pc_out, 8'h24)
    `CHK(pc_oe_n_out, 8'h88)
    `CHK(pc_alt_pin_out, 8'h2C)
    pc_alt_en_in <= 8'h00;
    @(posedge clk_in);
    $display("test port c done");
    wr(IDX_PD_DIR, 8'h0F);
    wr(IDX_PD_DATA, 8'h96);
    `CHK(pd_oe_n_out, 8'h0F)
    `CHK(pd_out | pd_oe_n_out, 8'h9F)
    `CHK(pd_ttl_sel_out, 1'b0)
    rdc(IDX_PD_DATA, 8'h90);
    $display("test port d done");
    rdc(IDX_PE_DATA, 8'h00);
    // Pins go digital before any of them is driven
    wr(IDX_ANA_CFG, 8'h00);
    wr(IDX_PE_DATA, 8'h05);
    wr(IDX_PE_CTRL, 8'h00);
    `CHK(pe_oe_n_out, 3'h0)
    `CHK(pe_out, 3'h5)
    wr(IDX_PE_CTRL, 8'h07);
    rdc(IDX_PE_DATA, 8'h07);
    $display("test port e done");
    wr(IDX_PE_CTRL, 8'h17);
    `CHK(pd_ttl_sel_out, 1'b1)
    `CHK(pe_ttl_sel_out, 1'b1)
    `CHK(pd_oe_n_out, 8'hFF)
    ext.ext_write(8'h5A);
    rdc(IDX_PE_CTRL, 8'h97);
    rdc(IDX_PD_DATA, 8'h5A);
    rdc(IDX_PE_CTRL, 8'h17);
    ext.ext_write(8'h11);
    ext.ext_write(8'h22);
    rdc(IDX_PE_CTRL, 8'hB7);
    wr(IDX_PE_CTRL, 8'h17);
    rdc(IDX_PE_CTRL, 8'h97);
    rdc(IDX_PD_DATA, 8'h22);
    wr(IDX_PD_DATA, 8'hC3);
    rdc(IDX_PE_CTRL, 8'h57);
    ext.ext_read(rd);
    `CHK(rd, 8'hC3)
    rdc(IDX_PE_CTRL, 8'h17);
    $display("test slave port done");
    other_rst_in <= 1'b1;
    @(posedge clk_in);
    other_rst_in <= 1'b0;
    @(posedge clk_in);
    rdc(IDX_PE_CTRL, 8'h07);
    rdc(IDX_PC_DIR, DIR_RST);
    wr(IDX_PC_DIR, 8'h00);
    `CHK(pc_out, 8'hA5)
    $display("test other reset done");
    conclude();
  end
endmodule
